// File: include/chain_host_pkg.sv
// Purpose: constants and types for the codec chain host controller
// Assumes: 16-bit serial words, at most one master and seven slaves
// Notes: register offsets are byte addresses on the local command port
package chain_host_pkg;
	localparam int WORD_BITS = 16;
	localparam int SLOT_BITS = 3;
	localparam int MAX_SLOTS = 8;
	localparam int ADDR_BITS = 8;
	localparam int DATA_BITS = 32;

	// Register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DIVIDERS = 8'h04;
	localparam logic [7:0] OFF_SEC_CMD = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_DELAY = 8'h10;
	// Word tables: 0x20..0x3C transmit, 0x40..0x5C receive
	localparam logic [2:0] SEL_TX_TABLE = 3'h1;
	localparam logic [2:0] SEL_RX_TABLE = 3'h2;

	// CTRL fields
	localparam int CTRL_SLAVES_LSB = 0;
	localparam int CTRL_SEC_REQ = 3;
	localparam int CTRL_TARGET_LSB = 4;
	localparam int CTRL_REPROG = 7;
	// STATUS fields
	localparam int ST_RX_NEW = 0;
	localparam int ST_CFG_ERR = 1;
	localparam int ST_SEC_BUSY = 2;
	localparam int ST_SLOT_LSB = 3;
	localparam int ST_RESYNC = 6;
	localparam int ST_TIMING_ERR = 7;
	localparam int ST_DELAY_ERR = 8;

	// Reset values
	localparam logic [7:0] RESET_DIV = 8'h12;
	localparam logic [7:0] RESET_DELAY = 8'h00;

	// Chain timing limits in shift clocks
	localparam logic [4:0] MIN_FRAME_SCLK = 5'h12;
	localparam logic [7:0] MIN_DELAY = 8'h12;
	localparam logic [15:0] SCLK_PER_SLOT_FACTOR = 16'h0048;
	localparam logic [15:0] REPROG_FACTOR = 16'h0090;
	localparam logic [1:0] REQ_BITS_ON = 2'h3;
	localparam logic [1:0] REQ_BITS_OFF = 2'h0;

	typedef enum logic {
		PH_IDLE,
		PH_SHIFT
	} phase_t;
endpackage

// File: rtl/chain_host.sv
// Purpose: host side of a serial port shared by a master codec and its chained slaves
// Assumes: shift clock and frame sync are made by the master; the serial pins are asynchronous
// Notes: the host only follows the chain; it never drives the shift clock or frame sync
// Notes: a status read clears the receive, resync and timing flags, and an event in that cycle wins
// What this block does
// - A secondary request puts ones in both low bits of every primary word once the chain limit holds, with up to six slaves.
// - Track slot and slave count; a primary word with LSB zero is the master.
// - Each frame period lasts at least sixteen plus two shift clocks.
// - Divider values are one shared setting for every device.
// - Program one slave by requesting secondaries from all, using its secondary slot.
// - Request secondaries of all devices or none, each in its own primary frame.
// - Frame-sync falls are at least eighteen shift clocks apart.
// - All primary frames fit within half of the sampling period.
// - Device count stays within master clock over 144 times sample rate.
// - When slaves are reprogrammed the limit is 288 times sample rate.
// - Never program the delay setting with one through seventeen.
`timescale 1ns/1ns
`default_nettype none

module chain_host (
	input wire logic mclk_i, // System clock, 20 MHz
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic [chain_host_pkg::ADDR_BITS-1:0] addr_i, // Command port address
	input wire logic [chain_host_pkg::DATA_BITS-1:0] wdata_i, // Command port write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [chain_host_pkg::DATA_BITS-1:0] rdata_o, // Read data, cycle after strobe
	input wire logic shift_clock_i, // Shift clock from the master
	input wire logic frame_sync_pin_i, // Frame sync from the master, active low
	input wire logic dev_data_i, // Serial data from the devices
	output logic host_data_o // Serial data to the devices
);
	import chain_host_pkg::*;

	typedef struct packed {
		phase_t phase;
		logic [2:0] sclk_sy;
		logic [2:0] fs_sy;
		logic [1:0] dat_sy;
		logic [3:0] bit_cnt;
		logic [WORD_BITS-1:0] tx_sh;
		logic [WORD_BITS-1:0] rx_sh;
		logic [3:0] frame_idx;
		logic [3:0] cur_frame;
		logic sec_active;
		logic [4:0] gap_cnt;
		logic gap_valid;
		logic [SLOT_BITS-1:0] slave_count;
		logic sec_req;
		logic [SLOT_BITS-1:0] target;
		logic reprog;
		logic [7:0] div_a;
		logic [7:0] div_b;
		logic [WORD_BITS-1:0] sec_cmd;
		logic [7:0] delay_set;
		logic rx_new;
		logic timing_err;
		logic delay_err;
		logic resync;
		logic [MAX_SLOTS-1:0][WORD_BITS-1:0] tx_mem;
		logic [MAX_SLOTS-1:0][WORD_BITS-1:0] rx_mem;
		logic [DATA_BITS-1:0] rdata;
		logic host_data;
	} ctl_state_t;

	ctl_state_t s;
	ctl_state_t next_s;

	// ==========================================================
	// Derived conditions
	logic sclk_rise;
	logic sclk_fall;
	logic fs_fall;
	logic [3:0] devices;
	logic [3:0] total_frames;
	logic [15:0] div_product;
	logic [15:0] slot_budget;
	logic cfg_err;
	logic is_primary;
	logic [3:0] sec_slot;
	logic [WORD_BITS-1:0] frame_word;
	logic [2:0] sel;
	logic [SLOT_BITS-1:0] tbl_idx;
	// Events of this cycle, kept apart so a status read cannot lose them
	logic rx_set;
	logic resync_set;
	logic terr_set;
	// Gap including a shift clock rise seen in the same cycle as the fall
	logic [5:0] gap_now;

	always_comb begin
		sclk_rise = s.sclk_sy[1] & ~s.sclk_sy[2];
		sclk_fall = ~s.sclk_sy[1] & s.sclk_sy[2];
		fs_fall = ~s.fs_sy[1] & s.fs_sy[2];
		devices = {1'b0, s.slave_count} + 4'h1;
		total_frames = s.sec_active ? {devices[2:0], 1'b0} : devices;
		// Shift clocks to first secondary are A*B/4; all primaries of 18 each must fit
		div_product = s.div_a * s.div_b;
		slot_budget = 16'(devices) * (s.reprog ? REPROG_FACTOR : SCLK_PER_SLOT_FACTOR);
		cfg_err = slot_budget > div_product;
		is_primary = s.frame_idx < devices;
		sec_slot = s.frame_idx - devices;
		// Frame sync falls on a shift clock rise; count that rise too
		gap_now = {1'b0, s.gap_cnt} + {5'h00, sclk_rise};
	end

	// ==========================================================
	// Word chosen for the frame that is starting
	always_comb begin
		frame_word = 16'h0000;
		if (is_primary) begin
			// Request bits are the same for every device of the sample
			frame_word = {s.tx_mem[s.frame_idx[2:0]][WORD_BITS-1:2],
				(s.sec_active || (s.frame_idx == 4'h0 && s.sec_req && !cfg_err))
				? REQ_BITS_ON : REQ_BITS_OFF};
		end else if (sec_slot[2:0] == s.target) begin
			frame_word = s.sec_cmd;
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		rx_set = 1'b0;
		resync_set = 1'b0;
		terr_set = 1'b0;
		sel = addr_i[7:5];
		tbl_idx = addr_i[4:2];
		// First stage feeds only the second; edges compare stages two and three
		next_s.sclk_sy = {s.sclk_sy[1:0], shift_clock_i};
		next_s.fs_sy = {s.fs_sy[1:0], frame_sync_pin_i};
		next_s.dat_sy = {s.dat_sy[0], dev_data_i};

		if (sclk_rise && s.gap_cnt != 5'h1F) begin
			next_s.gap_cnt = s.gap_cnt + 5'h01;
		end

		unique case (s.phase)
			PH_IDLE: begin
				if (fs_fall) begin
					// Exactly eighteen shift clocks apart is legal
					if (s.gap_valid && gap_now < {1'b0, MIN_FRAME_SCLK}) begin
						next_s.timing_err = 1'b1;
						terr_set = 1'b1;
					end
					next_s.gap_cnt = 5'h00;
					next_s.gap_valid = 1'b1;
					if (s.frame_idx == 4'h0) begin
						// Decide once per sample so all devices agree
						next_s.sec_active = s.sec_req && !cfg_err;
						if (s.sec_req && !cfg_err) begin
							next_s.sec_req = 1'b0;
						end
					end
					next_s.cur_frame = s.frame_idx;
					next_s.host_data = frame_word[WORD_BITS-1];
					next_s.tx_sh = {frame_word[WORD_BITS-2:0], 1'b0};
					next_s.bit_cnt = 4'h0;
					next_s.phase = PH_SHIFT;
				end
			end
			PH_SHIFT: begin
				if (sclk_rise) begin
					next_s.host_data = s.tx_sh[WORD_BITS-1];
					next_s.tx_sh = {s.tx_sh[WORD_BITS-2:0], 1'b0};
				end
				if (sclk_fall) begin
					next_s.rx_sh = {s.rx_sh[WORD_BITS-2:0], s.dat_sy[1]};
					next_s.bit_cnt = s.bit_cnt + 4'h1;
					if (s.bit_cnt == 4'hF) begin
						next_s.phase = PH_IDLE;
						next_s.rx_new = 1'b1;
						rx_set = 1'b1;
						next_s.rx_mem[s.cur_frame[2:0]] = {s.rx_sh[WORD_BITS-2:0], s.dat_sy[1]};
						if (s.cur_frame < devices && s.dat_sy[1] == 1'b0) begin
							// Master answers with LSB low: restart slot count here
							next_s.frame_idx = 4'h1;
							next_s.rx_mem[3'h0] = {s.rx_sh[WORD_BITS-2:0], s.dat_sy[1]};
							if (s.cur_frame != 4'h0) begin
								next_s.resync = 1'b1;
								resync_set = 1'b1;
							end
						end else if (s.cur_frame + 4'h1 >= total_frames) begin
							next_s.frame_idx = 4'h0;
							next_s.sec_active = 1'b0;
						end else begin
							next_s.frame_idx = s.cur_frame + 4'h1;
						end
					end
				end
			end
		endcase

		// ==========================================================
		// Command port writes
		next_s.rdata = '0;
		if (wr_i) begin
			if (addr_i == OFF_CTRL) begin
				next_s.slave_count = wdata_i[CTRL_SLAVES_LSB +: SLOT_BITS];
				next_s.sec_req = wdata_i[CTRL_SEC_REQ];
				next_s.target = wdata_i[CTRL_TARGET_LSB +: SLOT_BITS];
				next_s.reprog = wdata_i[CTRL_REPROG];
			end else if (addr_i == OFF_DIVIDERS) begin
				next_s.div_a = wdata_i[7:0];
				next_s.div_b = wdata_i[15:8];
			end else if (addr_i == OFF_SEC_CMD) begin
				next_s.sec_cmd = wdata_i[WORD_BITS-1:0];
			end else if (addr_i == OFF_DELAY) begin
				if (wdata_i[7:0] != 8'h00 && wdata_i[7:0] < MIN_DELAY) begin
					next_s.delay_err = 1'b1;
				end else begin
					next_s.delay_set = wdata_i[7:0];
					next_s.delay_err = 1'b0;
				end
			end else if (sel == SEL_TX_TABLE) begin
				next_s.tx_mem[tbl_idx] = wdata_i[WORD_BITS-1:0];
			end
		end

		// ==========================================================
		// Command port reads
		if (rd_i) begin
			if (addr_i == OFF_CTRL) begin
				next_s.rdata[CTRL_SLAVES_LSB +: SLOT_BITS] = s.slave_count;
				next_s.rdata[CTRL_SEC_REQ] = s.sec_req;
				next_s.rdata[CTRL_TARGET_LSB +: SLOT_BITS] = s.target;
				next_s.rdata[CTRL_REPROG] = s.reprog;
			end else if (addr_i == OFF_DIVIDERS) begin
				next_s.rdata[15:0] = {s.div_b, s.div_a};
			end else if (addr_i == OFF_SEC_CMD) begin
				next_s.rdata[WORD_BITS-1:0] = s.sec_cmd;
			end else if (addr_i == OFF_STATUS) begin
				next_s.rdata[ST_RX_NEW] = s.rx_new;
				next_s.rdata[ST_CFG_ERR] = cfg_err;
				next_s.rdata[ST_SEC_BUSY] = s.sec_active;
				next_s.rdata[ST_SLOT_LSB +: SLOT_BITS] = s.frame_idx[2:0];
				next_s.rdata[ST_RESYNC] = s.resync;
				next_s.rdata[ST_TIMING_ERR] = s.timing_err;
				next_s.rdata[ST_DELAY_ERR] = s.delay_err;
				// Reading clears; a same-cycle event keeps its flag
				next_s.rx_new = rx_set;
				next_s.resync = resync_set;
				next_s.timing_err = terr_set;
			end else if (addr_i == OFF_DELAY) begin
				next_s.rdata[7:0] = s.delay_set;
			end else if (sel == SEL_TX_TABLE) begin
				next_s.rdata[WORD_BITS-1:0] = s.tx_mem[tbl_idx];
			end else if (sel == SEL_RX_TABLE) begin
				next_s.rdata[WORD_BITS-1:0] = s.rx_mem[tbl_idx];
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.phase <= PH_IDLE;
			s.sclk_sy <= 3'h7;
			s.fs_sy <= 3'h7;
			s.div_a <= RESET_DIV;
			s.div_b <= RESET_DIV;
			s.delay_set <= RESET_DELAY;
		end else begin
			s <= next_s;
		end
	end

	assign rdata_o = s.rdata;
	assign host_data_o = s.host_data;

endmodule // chain_host

`default_nettype wire

// File: bench/chain_host_properties.sv
// Purpose: port checks for the chain host command port
// Assumes: register map of chain_host_pkg
// Notes: shadows of CTRL and DIVIDERS mirror the writes
`timescale 1ns/1ns
`default_nettype none
module chain_host_properties (
	input wire logic mclk_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic [chain_host_pkg::ADDR_BITS-1:0] addr_i, // Address
	input wire logic [chain_host_pkg::DATA_BITS-1:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	input wire logic [chain_host_pkg::DATA_BITS-1:0] rdata_o, // Read data
	input wire logic shift_clock_i, // Shift clock
	input wire logic frame_sync_pin_i, // Frame sync
	input wire logic dev_data_i, // Device data
	input wire logic host_data_o // Host data
);
	import chain_host_pkg::*;
	typedef struct packed {logic [7:0] ctl; logic [7:0] da; logic [7:0] db;} shadow_t;
	shadow_t s, next_s;
	logic cfg_exp;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========
	// Shadows
	always_comb begin
		next_s = s;
		if (!rst_n_i) next_s = '{8'h00, RESET_DIV, RESET_DIV};
		else if (wr_i && addr_i == OFF_CTRL) next_s.ctl = wdata_i[7:0];
		else if (wr_i && addr_i == OFF_DIVIDERS) next_s = '{s.ctl, wdata_i[7:0], wdata_i[15:8]};
	end
	always_ff @(posedge mclk_i) s <= next_s;
	assign cfg_exp = (int'(s.ctl[2:0]) + 1) * (s.ctl[7] ? 144 : 72) > int'(s.da) * int'(s.db);
	// ==========
	// Checks
	property p_rst_quiet; $rose(rst_n_i) |-> rdata_o == 32'h0 && !host_data_o; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet");
	property p_rd_only; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
	a_rd_only: assert property (p_rd_only) else $error("read data without read");
	property p_unmapped; rd_i && addr_i == 8'h1C |=> rdata_o == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_dly_range; rd_i && addr_i == OFF_DELAY |=> !(rdata_o[7:0] inside {[1:17]}); endproperty
	a_dly_range: assert property (p_dly_range) else $error("delay holds 1..17");
	property p_dly_bad;
		wr_i && addr_i == OFF_DELAY && wdata_i[7:0] inside {[1:17]} ##[1:3]
		rd_i && addr_i == OFF_STATUS |=> rdata_o[ST_DELAY_ERR];
	endproperty
	a_dly_bad: assert property (p_dly_bad) else $error("bad delay not flagged");
	property p_dly_good;
		wr_i && addr_i == OFF_DELAY && !(wdata_i[7:0] inside {[1:17]}) ##[1:3]
		rd_i && addr_i == OFF_STATUS |=> !rdata_o[ST_DELAY_ERR];
	endproperty
	a_dly_good: assert property (p_dly_good) else $error("good delay flagged");
	property p_cfg;
		rd_i && addr_i == OFF_STATUS && !$past(wr_i) |=> rdata_o[ST_CFG_ERR] == cfg_exp;
	endproperty
	a_cfg: assert property (p_cfg) else $error("chain limit flag wrong");
	property p_ctrl;
		rd_i && addr_i == OFF_CTRL |=> rdata_o[2:0] == s.ctl[2:0] && rdata_o[7:4] == s.ctl[7:4];
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
	property p_div; rd_i && addr_i == OFF_DIVIDERS |=> rdata_o[15:0] == {s.db, s.da}; endproperty
	a_div: assert property (p_div) else $error("divider readback wrong");
endmodule // chain_host_properties
bind chain_host chain_host_properties chain_host_properties_i (.mclk_i(mclk_i),
	.rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .shift_clock_i(shift_clock_i), .frame_sync_pin_i(frame_sync_pin_i),
	.dev_data_i(dev_data_i), .host_data_o(host_data_o));
`default_nettype wire

// File: bench/chain_device_model.sv
// Purpose: behavioural master codec with chained slaves
// Assumes: one shared frame sync line to the host
// Notes: word = slot, kind bit, 0x3C; slaves force LSB 1
`timescale 1ns/1ns
`default_nettype none
module chain_device_model #(
	parameter int DIV_A = 18, // Shared divider A
	parameter int DIV_B = 18, // Shared divider B
	parameter int DELAY = 18, // Frame-sync spacing
	parameter int SLAVES = 2 // Chained slaves
) (
	input wire logic dev_mclk_i, // Device master clock
	input wire logic din_i, // Host to devices
	output logic sclk_o, // Shift clock
	output logic fs_n_o, // Frame sync, active low
	output logic dout_o // Devices to host
);
	logic [1:0] div = 2'h0;
	logic [15:0] rx_pri [8];
	logic [15:0] rx_sec [8];
	int periods = 0;
	int e;
	always @(posedge dev_mclk_i) div <= div + 2'h1;
	assign sclk_o = div[1];
	task automatic go(input int t);
		repeat (t - e) @(posedge sclk_o);
		e = t;
	endtask
	task automatic xfer(input int d, input logic s, output logic [15:0] rx);
		logic [15:0] tx;
		tx = {d[3:0], 3'h0, s, 8'h3C} | 16'(d != 0);
		fs_n_o = 1'b0;
		dout_o = tx[15];
		for (int b = 0; b < 16; b++) begin
			@(posedge sclk_o);
			rx = {rx[14:0], din_i}; // A rise late: margin for host sync lag
			if (b < 15) dout_o = tx[14 - b];
		end
		fs_n_o = 1'b1;
		dout_o = ~dout_o; // Released line shows no stale bit
		e = e + 16;
	endtask
	initial begin
		fs_n_o = 1'b1;
		dout_o = 1'b0;
		e = 0;
		go(40);
		forever begin
			e = 0;
			periods++;
			for (int d = 0; d <= SLAVES; d++) begin
				go(d * DELAY);
				xfer(d, 1'b0, rx_pri[d]);
			end
			if (rx_pri[0][1:0] == 2'b11) begin
				for (int d = 0; d <= SLAVES; d++) begin
					go(DIV_A * DIV_B / 4 + d * DELAY);
					xfer(d, 1'b1, rx_sec[d]);
				end
			end
			go(DIV_A * DIV_B / 2);
		end
	end
endmodule // chain_device_model
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: register and link test of the chain host
// Assumes: device model with two slaves and delay 18
// Notes: link clock 400 ns from a 100 ns device clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import chain_host_pkg::*;
	logic mclk_i = 1'b0;
	logic dev_mclk = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o, v;
	logic sclk, fs_n, dout, host_data_o;
	int fails = 0;
	int checks_done = 0;
	int q;
	logic [31:0] cv [4] = '{32'h02, 32'h82, 32'h81, 32'h02};
	logic [31:0] dv [4] = '{32'h1208, 32'h1212, 32'h1212, 32'h1212};
	always #25 mclk_i = ~mclk_i;
	always #50 dev_mclk = ~dev_mclk;
	chain_host chain_host_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .shift_clock_i(sclk),
		.frame_sync_pin_i(fs_n), .dev_data_i(dout), .host_data_o(host_data_o));
	chain_device_model chain_device_model_i (.dev_mclk_i(dev_mclk), .din_i(host_data_o),
		.sclk_o(sclk), .fs_n_o(fs_n), .dout_o(dout));
	// ==========
	// Tasks
	task automatic end_sim();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic waitp(input int n);
		for (int k = 0; k < 4000 && chain_device_model_i.periods < n; k++) begin
			@(posedge mclk_i);
		end
		if (chain_device_model_i.periods < n) begin
			fails++;
			$display("[FAIL] %0t timeout waiting for sample period %0d", $time, n);
			end_sim();
		end
	endtask
	// ==========
	// Sequence
	initial begin
		repeat (12) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rd(OFF_CTRL);
		chk(v, 32'h0);
		rd(OFF_DIVIDERS);
		chk(v, 32'h1212);
		rd(8'h1C);
		chk(v, 32'h0);
		wr(OFF_DELAY, 32'h11);
		rd(OFF_STATUS);
		chk(v & 32'h100, 32'h100);
		rd(OFF_DELAY);
		chk(v, 32'h0);
		wr(OFF_DELAY, 32'h12);
		rd(OFF_STATUS);
		chk(v & 32'h100, 32'h0);
		rd(OFF_DELAY);
		chk(v, 32'h12);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CTRL, cv[i]);
			wr(OFF_DIVIDERS, dv[i]);
			rd(OFF_STATUS);
			chk(v & 32'h2, (i < 2) ? 32'h2 : 32'h0);
		end
		$display("test limits done");
		for (int i = 0; i < 3; i++) begin
			wr(8'h20 + 8'(4 * i), 32'h4C71 + 32'h1000 * i);
		end
		wr(OFF_SEC_CMD, 32'h7E5D);
		waitp(1);
		repeat (100) @(posedge mclk_i);
		q = chain_device_model_i.periods;
		wr(OFF_CTRL, 32'h2A);
		waitp(q + 2);
		for (int d = 0; d < 3; d++) begin
			chk(32'(chain_device_model_i.rx_pri[d]), 32'h4C73 + 32'h1000 * d);
			chk(32'(chain_device_model_i.rx_sec[d]), (d == 2) ? 32'h7E5D : 32'h0);
		end
		for (int i = 0; i < 6; i++) begin
			rd(8'h40 + 8'(4 * i));
			chk(v, {16'h0, 4'(i % 3), 3'h0, 1'(i / 3), 8'h3C} | 32'(i % 3 != 0));
		end
		rd(OFF_STATUS);
		chk(v & 32'hC0, 32'h0);
		waitp(q + 3);
		for (int d = 0; d < 3; d++) begin
			chk(32'(chain_device_model_i.rx_pri[d] & 16'h3), 32'h0);
		end
		$display("test chain done");
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
